// ==== include/ipp_pkg.sv ====
// Package for the interrupt priority and pending block.
// Assumes a 32-input controller, a 32-bit classic Wishbone register bus
// and one 200 MHz processor clock.
package ipp_pkg;

	// -----------------------------------------------------------------
	// Sizes
	// -----------------------------------------------------------------
	localparam int IRQ_COUNT  = 32;
	localparam int PRIO_W     = 2;
	localparam int PRIO_WORDS = 8;
	localparam int NUM_W      = 5;
	localparam int ADR_W      = 8;
	localparam int DAT_W      = 32;
	localparam int LANE_W     = 8;

	// -----------------------------------------------------------------
	// Register byte offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_ENA_SET    = 8'h00;
	localparam logic [7:0] OFS_ENA_CLR    = 8'h04;
	localparam logic [7:0] OFS_PEND_SET   = 8'h08;
	localparam logic [7:0] OFS_PEND_CLR   = 8'h0c;
	localparam logic [7:0] OFS_PULSE_MODE = 8'h10;
	localparam logic [7:0] OFS_ACTIVE     = 8'h14;
	localparam logic [7:0] OFS_WINNER     = 8'h18;
	localparam logic [7:0] OFS_PRIO_BASE  = 8'h20;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int PRIO_LSB      = 6;
	localparam int WIN_VALID_BIT = 31;
	localparam int WIN_NUM_LSB   = 8;
	localparam int WIN_PRI_LSB   = 0;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
	localparam logic [31:0] RST_PULSE  = 32'h0000_0000;
	localparam logic [1:0]  RST_PRIO   = 2'h0;

	// Per-interrupt state
	typedef enum logic [1:0] {
		ST_INACTIVE,
		ST_PENDING,
		ST_ACTIVE,
		ST_ACT_PEND
	} ipp_state_e;

endpackage

// ==== rtl/ipp_controller.sv ====
// Priority storage, per-interrupt state and winner selection for a
// 32-input nested interrupt controller, with a Wishbone register port.
// Assumes interrupt lines and handler strobes come from logic on clk.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module ipp_controller (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Peripheral interrupt lines
	input  wire logic [31:0] irqLines,
	// Processor handler entry and return
	input  wire logic        handlerEnter,
	input  wire logic [4:0]  enterNum,
	input  wire logic        handlerExit,
	input  wire logic [4:0]  exitNum,
	// Winning interrupt offered to the processor
	output logic             takeValid,
	output logic      [4:0]  takeNum,
	output logic      [1:0]  takePri
);

	// -----------------------------------------------------------------
	// Storage
	// -----------------------------------------------------------------
	logic [ipp_pkg::PRIO_W-1:0] prio_r [ipp_pkg::IRQ_COUNT];
	logic [31:0]                enable_r;
	logic [31:0]                pulse_r;
	logic [31:0]                linePrev_r;
	logic                       ack_r;
	logic [31:0]                rdat_r;
	logic                       takeValid_r;
	logic [4:0]                 takeNum_r;
	logic [1:0]                 takePri_r;

	// -----------------------------------------------------------------
	// Bus decode
	// -----------------------------------------------------------------
	logic        busReq;
	logic        wrNow;
	logic        fullWord;
	logic        isPrio;
	logic [2:0]  prioWord;
	logic [31:0] pendVec;
	logic [31:0] actVec;
	logic [31:0] setPendVec;
	logic [31:0] clrPendVec;
	logic [31:0] enterHot;
	logic [31:0] leaveHot;
	logic [31:0] rdat_nxt;
	logic [31:0] winWord;

	// Request present; write commits on the edge that sees ack
	assign busReq   = wb_cyc_i & wb_stb_i;
	assign wrNow    = busReq & wb_we_i & ack_r;
	assign fullWord = (wb_sel_i == 4'hf);

	// Priority word window and index
	assign isPrio   = (wb_adr_i[7:5] == ipp_pkg::OFS_PRIO_BASE[7:5]);
	assign prioWord = wb_adr_i[4:2];

	// -----------------------------------------------------------------
	// Wishbone handshake
	// -----------------------------------------------------------------

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk) begin
		if (!rst_n)
			ack_r <= 1'b0;
		else if (ce)
			ack_r <= busReq & ~ack_r;
	end

	// Read data captured as ack rises
	always_ff @(posedge clk) begin
		if (!rst_n)
			rdat_r <= 32'h0000_0000;
		else if (ce && busReq && !ack_r)
			rdat_r <= rdat_nxt;
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// -----------------------------------------------------------------
	// Software strobes
	// -----------------------------------------------------------------

	// Set and clear pending pulses, one cycle, only on commit
	always_comb begin
		setPendVec = 32'h0000_0000;
		clrPendVec = 32'h0000_0000;
		if (wrNow && fullWord) begin
			if (wb_adr_i == ipp_pkg::OFS_PEND_SET)
				setPendVec = wb_dat_i;
			if (wb_adr_i == ipp_pkg::OFS_PEND_CLR)
				clrPendVec = wb_dat_i;
		end
	end

	// Handler entry and return as one-hot vectors
	assign enterHot = handlerEnter ? (32'h0000_0001 << enterNum)
	                               : 32'h0000_0000;
	assign leaveHot = handlerExit ? (32'h0000_0001 << exitNum)
	                              : 32'h0000_0000;

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------

	// Enable set and clear; enable gates only selection
	always_ff @(posedge clk) begin
		if (!rst_n)
			enable_r <= ipp_pkg::RST_ENABLE;
		else if (ce && wrNow && fullWord) begin
			if (wb_adr_i == ipp_pkg::OFS_ENA_SET)
				enable_r <= enable_r | wb_dat_i;
			else if (wb_adr_i == ipp_pkg::OFS_ENA_CLR)
				enable_r <= enable_r & ~wb_dat_i;
		end
	end

	// Detection mode per interrupt, one means pulse
	always_ff @(posedge clk) begin
		if (!rst_n)
			pulse_r <= ipp_pkg::RST_PULSE;
		else if (ce && wrNow && fullWord &&
		         wb_adr_i == ipp_pkg::OFS_PULSE_MODE)
			pulse_r <= wb_dat_i;
	end

	// Priority fields; only the top two lane bits are kept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < ipp_pkg::IRQ_COUNT; i++)
				prio_r[i] <= ipp_pkg::RST_PRIO;
		end else if (ce && wrNow && isPrio && fullWord) begin
			for (int k = 0; k < 4; k++)
				prio_r[{prioWord, 2'(k)}] <=
					wb_dat_i[k*ipp_pkg::LANE_W+ipp_pkg::PRIO_LSB +:
					         ipp_pkg::PRIO_W];
		end
	end

	// -----------------------------------------------------------------
	// Line sampling
	// -----------------------------------------------------------------

	// Previous line level for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n)
			linePrev_r <= 32'h0000_0000;
		else if (ce)
			linePrev_r <= irqLines;
	end

	// -----------------------------------------------------------------
	// Per-interrupt state machines
	// -----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ipp_pkg::IRQ_COUNT; g++) begin : gIrq
			ipp_irq_state uState (
				.clk     (clk),
				.rst_n   (rst_n),
				.ce      (ce),
				.isPulse (pulse_r[g]),
				.lineNow (irqLines[g]),
				.linePrev(linePrev_r[g]),
				.setPend (setPendVec[g]),
				.clrPend (clrPendVec[g]),
				.enter   (enterHot[g]),
				.leave   (leaveHot[g]),
				.pending (pendVec[g]),
				.active  (actVec[g])
			);
		end
	endgenerate

	// -----------------------------------------------------------------
	// Winner selection
	// -----------------------------------------------------------------
	logic [31:0] candidate;
	logic        bestFound;
	logic [4:0]  bestNum;
	logic [1:0]  bestPri;

	// Disabled pending interrupts never compete
	assign candidate = pendVec & enable_r;

	// Lowest value wins; downward scan keeps the lower number on ties
	always_comb begin
		bestFound = 1'b0;
		bestNum   = 5'h00;
		bestPri   = 2'h0; // Idle offer matches the reset value
		for (int i = ipp_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
			if (candidate[i] &&
			    (!bestFound || prio_r[i] <= bestPri)) begin
				bestFound = 1'b1;
				bestNum   = 5'(i);
				bestPri   = prio_r[i];
			end
		end
	end

	// Registered offer to the processor
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			takeValid_r <= 1'b0;
			takeNum_r   <= 5'h00;
			takePri_r   <= 2'h0;
		end else if (ce) begin
			takeValid_r <= bestFound;
			takeNum_r   <= bestNum;
			takePri_r   <= bestPri;
		end
	end

	assign takeValid = takeValid_r;
	assign takeNum   = takeNum_r;
	assign takePri   = takePri_r;

	// -----------------------------------------------------------------
	// Read-back
	// -----------------------------------------------------------------

	// Winner status word
	always_comb begin
		winWord = 32'h0000_0000;
		winWord[ipp_pkg::WIN_VALID_BIT] = takeValid_r;
		winWord[ipp_pkg::WIN_NUM_LSB +: ipp_pkg::NUM_W] = takeNum_r;
		winWord[ipp_pkg::WIN_PRI_LSB +: ipp_pkg::PRIO_W] = takePri_r;
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdat_nxt = 32'h0000_0000;
		if (isPrio) begin
			for (int k = 0; k < 4; k++)
				rdat_nxt[k*ipp_pkg::LANE_W+ipp_pkg::PRIO_LSB +:
				         ipp_pkg::PRIO_W] =
					prio_r[{prioWord, 2'(k)}];
		end else begin
			unique case (wb_adr_i)
				ipp_pkg::OFS_ENA_SET:    rdat_nxt = enable_r;
				ipp_pkg::OFS_ENA_CLR:    rdat_nxt = enable_r;
				ipp_pkg::OFS_PEND_SET:   rdat_nxt = pendVec;
				ipp_pkg::OFS_PEND_CLR:   rdat_nxt = pendVec;
				ipp_pkg::OFS_PULSE_MODE: rdat_nxt = pulse_r;
				ipp_pkg::OFS_ACTIVE:     rdat_nxt = actVec;
				ipp_pkg::OFS_WINNER:     rdat_nxt = winWord;
				default:                 rdat_nxt = 32'h0000_0000;
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== rtl/ipp_irq_state.sv ====
// State tracker for one interrupt: inactive, pending, active,
// active and pending.
// Assumes all inputs are on clk; set and clear strobes are one cycle.
`timescale 1ns/1ps
`default_nettype none

module ipp_irq_state (
	// Clock, reset, enable
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Line and mode
	input  wire logic isPulse,
	input  wire logic lineNow,
	input  wire logic linePrev,
	// Software strobes
	input  wire logic setPend,
	input  wire logic clrPend,
	// Handler entry and return
	input  wire logic enter,
	input  wire logic leave,
	// Status
	output logic      pending,
	output logic      active
);

	ipp_pkg::ipp_state_e state_r;
	ipp_pkg::ipp_state_e state_nxt;
	logic                rise;
	logic                lvlHigh;
	logic                newPend;

	// Event sources
	assign rise    = lineNow & ~linePrev;
	assign lvlHigh = ~isPulse & lineNow;
	assign newPend = setPend | rise;

	// Next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ipp_pkg::ST_INACTIVE: begin
				if (newPend || lvlHigh)
					state_nxt = ipp_pkg::ST_PENDING;
			end
			ipp_pkg::ST_PENDING: begin
				if (enter)
					state_nxt = ipp_pkg::ST_ACTIVE;
				else if (clrPend && !newPend && !lvlHigh)
					state_nxt = ipp_pkg::ST_INACTIVE;
			end
			ipp_pkg::ST_ACTIVE: begin
				if (leave) begin
					if (newPend || lvlHigh)
						state_nxt = ipp_pkg::ST_PENDING;
					else
						state_nxt = ipp_pkg::ST_INACTIVE;
				end else if (newPend) begin
					state_nxt = ipp_pkg::ST_ACT_PEND;
				end
			end
			ipp_pkg::ST_ACT_PEND: begin
				if (leave)
					state_nxt = ipp_pkg::ST_PENDING;
				else if (enter)
					state_nxt = ipp_pkg::ST_ACTIVE;
				else if (clrPend && !newPend && !lvlHigh)
					state_nxt = ipp_pkg::ST_ACTIVE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n)
			state_r <= ipp_pkg::ST_INACTIVE;
		else if (ce)
			state_r <= state_nxt;
	end

	// Decoded status
	assign pending = (state_r == ipp_pkg::ST_PENDING) ||
	                 (state_r == ipp_pkg::ST_ACT_PEND);
	assign active  = (state_r == ipp_pkg::ST_ACTIVE) ||
	                 (state_r == ipp_pkg::ST_ACT_PEND);

endmodule

`default_nettype wire

// ==== testbench/ipp_controller_tb.sv ====
// Self-checking bench for ipp_controller with a core model.
// Assumes the checker and core model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ipp_controller_tb;
	typedef struct {
		logic [7:0]  adr;
		logic [31:0] wd;
		logic [31:0] exp;
	} ipp_row_s;
	logic        clk, rst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, irqLines;
	logic        handlerEnter, handlerExit, takeValid, accept, retire, busy;
	logic [4:0]  enterNum, exitNum, takeNum;
	logic [1:0]  takePri;
	int          fails, check_count;
	ipp_row_s    rows [6] = '{'{8'h20, 32'hffffffff, 32'hc0c0c0c0},
		'{8'h3c, 32'h12345678, 32'h00004040},
		'{8'h24, 32'h8040c000, 32'h8040c000},
		'{8'h40, 32'hffffffff, 32'h0}, '{8'h14, 32'hffffffff, 32'h0},
		'{8'h10, 32'h10, 32'h10}};
	ipp_controller i_ipp_controller (.clk, .rst_n, .ce, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .irqLines, .handlerEnter, .enterNum, .handlerExit,
		.exitNum, .takeValid, .takeNum, .takePri);
	ipp_core_model i_ipp_core_model (.clk, .rst_n, .takeValid, .takeNum,
		.accept, .retire, .handlerEnter, .enterNum, .handlerExit,
		.exitNum, .busy);
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a; // Word-aligned offsets only
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hf, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, 4'hf, q);
		check("read data", q, e);
	endtask
	task automatic winner(input logic [31:0] e);
		repeat (2) @(posedge clk);
		check("winner", 32'({takeValid, takeNum, takePri}), e);
	endtask
	task automatic take();
		int n;
		n = 0;
		accept <= 1'b1;
		while (busy !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		accept <= 1'b0;
		check("handler entry", {31'h0, busy}, 32'h1);
	endtask
	task automatic retireOne();
		retire <= 1'b1;
		@(posedge clk);
		retire <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic pulseFour();
		irqLines[4] <= 1'b1; // One full cycle high
		@(posedge clk);
		irqLines[4] <= 1'b0;
		@(posedge clk);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Watchdog
	initial begin
		#20000;
		fails++;
		close_out();
	end
	// Main sequence
	initial begin
		logic [31:0] q;
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, accept, retire} = 6'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i, irqLines} = '0;
		ce = 1'b1;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) rd(8'(32 + 4 * i), 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].adr, rows[i].wd);
			rd(rows[i].adr, rows[i].exp);
		end
		wb(1'b1, 8'h28, 32'hffffffff, 4'h1, q);
		rd(8'h28, 32'h0);
		for (int i = 0; i < 8; i++) wr(8'(32 + 4 * i), 32'hc0c0c0c0);
		wr(8'h24, 32'hc040c0c0);
		wr(8'h28, 32'hc0c040c0);
		wr(8'h08, 32'h00001240);
		rd(8'h08, 32'h00001240);
		winner(32'h0);
		wr(8'h00, 32'hffffffff);
		winner(32'h99);
		wr(8'h0c, 32'h40);
		winner(32'ha5);
		wr(8'h2c, 32'hc0c0c000);
		winner(32'hb0);
		rd(8'h18, 32'h80000c00);
		wr(8'h04, 32'h00001000);
		winner(32'ha5);
		rd(8'h00, 32'hffffefff);
		rd(8'h08, 32'h00001200);
		wr(8'h0c, 32'hffffffff);
		irqLines[3] <= 1'b1;
		take();
		rd(8'h14, 32'h8);
		rd(8'h08, 32'h0);
		retireOne();
		rd(8'h08, 32'h8);
		wr(8'h0c, 32'h8);
		rd(8'h08, 32'h8);
		irqLines[3] <= 1'b0;
		wr(8'h0c, 32'h8);
		rd(8'h08, 32'h0);
		pulseFour();
		take();
		pulseFour();
		rd(8'h08, 32'h10);
		wr(8'h0c, 32'h10);
		rd(8'h08, 32'h0);
		rd(8'h14, 32'h10);
		retireOne();
		rd(8'h14, 32'h0);
		rd(8'h08, 32'h0);
		pulseFour();
		take();
		pulseFour();
		retireOne();
		rd(8'h08, 32'h10);
		// Frozen clock enable: a short level request goes unseen
		ce <= 1'b0;
		irqLines[3] <= 1'b1;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		irqLines[3] <= 1'b0;
		rd(8'h08, 32'h10);
		// Mid-run reset clears offer, states and priorities
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check("offer after reset", {29'h0, takeValid, takePri}, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h2c, 32'h0);
		close_out();
	end
endmodule
bind ipp_controller ipp_ctrl_assertions i_ipp_ctrl_assertions (.clk,
	.rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .irqLines, .handlerEnter, .enterNum, .handlerExit,
	.takeValid, .takeNum, .takePri);
`default_nettype wire

// ==== testbench/ipp_core_model.sv ====
// Processor core model: takes the offered interrupt and returns on command.
// Assumes the winner outputs of ipp_controller and one clock.
`timescale 1ns/1ps
`default_nettype none
module ipp_core_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Winner and bench control
	input  wire logic       takeValid,
	input  wire logic [4:0] takeNum,
	input  wire logic       accept,
	input  wire logic       retire,
	// Handler strobes
	output logic            handlerEnter,
	output logic      [4:0] enterNum,
	output logic            handlerExit,
	output logic      [4:0] exitNum,
	output logic            busy
);
	logic [1:0] coolCnt_r;
	// Enter only an offered winner; wait out the stale offer
	always_ff @(posedge clk) begin
		handlerEnter <= 1'b0;
		handlerExit  <= 1'b0;
		if (!rst_n) begin
			busy      <= 1'b0;
			coolCnt_r <= 2'h0;
			enterNum  <= 5'h0;
			exitNum   <= 5'h0;
		end else if (busy && retire) begin
			busy        <= 1'b0;
			handlerExit <= 1'b1;
			coolCnt_r   <= 2'h3;
		end else if (!busy && coolCnt_r != 2'h0) begin
			coolCnt_r <= coolCnt_r - 2'h1;
		end else if (!busy && accept && takeValid) begin
			busy         <= 1'b1;
			handlerEnter <= 1'b1;
			enterNum     <= takeNum;
			exitNum      <= takeNum;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/ipp_ctrl_assertions.sv ====
// Checker for the interrupt priority and pending block.
// Assumes it is bound to ipp_controller and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ipp_ctrl_assertions (
	// Clock, reset, enable
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        ce,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Lines and handler strobes
	input wire logic [31:0] irqLines,
	input wire logic        handlerEnter,
	input wire logic [4:0]  enterNum,
	input wire logic        handlerExit,
	// Winner
	input wire logic        takeValid,
	input wire logic [4:0]  takeNum,
	input wire logic [1:0]  takePri
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);
	logic rdAck;
	logic quiet;
	// Read answers and cycles without events
	assign rdAck = wb_ack_o && !wb_we_i;
	assign quiet = !wb_ack_o && !handlerEnter && !handlerExit;
	chk_ack_next: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack did not follow request");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_lane_low: assert property (
		rdAck && wb_adr_i[7:5] == 3'h1 |-> !(wb_dat_o & 32'h3f3f3f3f))
		else $error("priority low bits not zero");
	chk_unmapped_zero: assert property (
		rdAck && wb_adr_i[7:6] != 2'h0 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_winner_rsvd: assert property (
		rdAck && wb_adr_i == ipp_pkg::OFS_WINNER
		|-> wb_dat_o[30:13] == 18'h0 && wb_dat_o[7:2] == 6'h0)
		else $error("winner reserved bits set");
	chk_enter_clears: assert property (
		handlerEnter && $stable(irqLines) && !wb_ack_o
		##1 quiet && $stable(irqLines)
		|=> !(takeValid && takeNum == $past(enterNum, 2)))
		else $error("entered interrupt still offered");
	chk_rise_cause: assert property ($rose(takeValid)
		|-> $past(irqLines, 2) != 32'h0 || $past(handlerExit, 2) ||
		    $past(wb_ack_o, 2) && $past(wb_we_i, 2))
		else $error("winner without a cause");
	chk_win_hold: assert property (
		quiet && $stable(irqLines) ##1 quiet && $stable(irqLines)
		|=> $stable(takeValid) && $stable(takeNum) && $stable(takePri))
		else $error("winner changed without event");
	// Main scenarios reached
	cov_read: cover property (rdAck);
	cov_enter: cover property (handlerEnter);
	cov_offer: cover property ($rose(takeValid));
endmodule
`default_nettype wire
